// *** rtl/pi_cascade_regs.vh ***
// What this block does
// - Position, velocity, current PI stages cascaded
// - Current stage always runs
// - Velocity stage off in unlimited torque
// - Position stage on in position-type modes
// - Position stage in velocity modes when bit1
// - Each stage output clamped to its limit
// - Kp 100% maps max deviation to limit
// - Proportional output linear in gain
// - Reset time zero clears integral term
// - Integral weight inverse to reset time
// - Legacy parameter set used by default
// - Selector zero converts legacy at power-on
// - Velocity feed-forward added before velocity stage
// - Velocity feed-forward only with position stage
// - Acceleration feed-forward added before current stage
// - Acceleration feed-forward off in torque modes
// - 50% factor gives 50% current at start
// - Voltage feed-forward added to current output
// - Voltage feed-forward everywhere, zero disables
// - Step pulses scaled by multiplier over divider
`ifndef PI_CASCADE_REGS_VH
`define PI_CASCADE_REGS_VH
// ----------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------
`define MODE_PROF_POS 4'h1
`define MODE_VELOCITY 4'h2
`define MODE_PROF_VEL 4'h3
`define MODE_PROF_TRQ 4'h4
`define MODE_HOMING 4'h6
`define MODE_INTERP_POS 4'h7
`define MODE_CYC_POS 4'h8
`define MODE_CYC_VEL 4'h9
`define MODE_CYC_TRQ 4'ha
`define MODE_CLK_DIR 4'hb
// ----------------------------------------------------------------
// Configuration bits and scaling
// ----------------------------------------------------------------
`define CFG_POS_IN_VEL_BIT 1
`define CFG_REAL_TORQUE_BIT 5
`define GAIN_FULL 16'h03e8
`define VFF_DEFAULT 16'h03e8
`define TN_SCALE 32'h0000_0400
`endif

// *** rtl/pi_stage.v ***
`timescale 1ns/100ps
`include "pi_cascade_regs.vh"
// One PI stage: y = clamp(kp*e*ymax/(1000*emax) + integral), done combinationally per cycle
module pi_stage
(
  input wire i_clk_sys, // System clock
  input wire i_rst_b, // Async reset, active low
  input wire i_run, // Stage active
  input wire signed [31:0] i_err, // Control deviation
  input wire [15:0] i_kp, // Gain in tenths of a percent
  input wire [15:0] i_tn, // Reset time, 0 disables integral
  input wire [31:0] i_emax, // Maximum deviation
  input wire [31:0] i_ymax, // Output limit
  output wire signed [31:0] o_y // Clamped output
);

  reg signed [31:0] integ_ff;
  reg signed [31:0] nxt_integ;
  wire signed [63:0] lim = $signed({32'h0, i_ymax});
  wire [31:0] emax_nz = (i_emax == 32'h0) ? 32'h1 : i_emax;
  wire signed [63:0] prop_num = i_err * $signed({32'h0, i_ymax});
  wire signed [63:0] prop_g = prop_num * $signed({48'h0, i_kp});
  wire signed [63:0] p_term = prop_g / ($signed({32'h0, emax_nz}) * 64'sd1000);
  wire signed [63:0] int_step = (p_term * $signed(`TN_SCALE)) /
                                $signed({48'h0, (i_tn == 16'h0) ? 16'h1 : i_tn});
  wire signed [63:0] int_sum = {{32{integ_ff[31]}}, integ_ff} + (int_step >>> 10);
  wire signed [63:0] y_sum = p_term + {{32{integ_ff[31]}}, integ_ff};

  function signed [31:0] clamp;
    input signed [63:0] v;
    input signed [63:0] l;
    begin
      if (v > l)
        clamp = l[31:0];
      else if (v < -l)
        clamp = -l[31:0];
      else
        clamp = v[31:0];
    end
  endfunction

  always @*
  begin
    if (!i_run || i_tn == 16'h0)
      nxt_integ = 32'sh0;
    else
      nxt_integ = clamp(int_sum, lim);
  end

  always @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      integ_ff <= 32'sh0;
    else
      integ_ff <= nxt_integ;
  end

  assign o_y = i_run ? clamp(y_sum, lim) : 32'sh0;

endmodule // pi_stage

// *** rtl/cascaded_pi_motor_control.v ***
`timescale 1ns/100ps
`include "pi_cascade_regs.vh"
module cascaded_pi_motor_control
(
  input wire i_clk_sys, // System clock 100 MHz
  input wire i_rst_b, // Async reset, active low
  input wire [3:0] i_mode, // Operating mode
  input wire [7:0] i_cfg, // Drive submode configuration
  input wire i_legacy_sel, // Legacy selector, 1 = old parameters
  input wire signed [31:0] i_pos_set, // Position set point
  input wire signed [31:0] i_pos_act, // Actual position
  input wire signed [31:0] i_vel_set, // Velocity set point (no position loop)
  input wire signed [31:0] i_vel_act, // Actual velocity
  input wire signed [31:0] i_cur_set, // Current set point (torque modes with bit 5, velocity stage off)
  input wire signed [31:0] i_cur_act, // Actual current
  input wire signed [31:0] i_ramp_vel, // Ramp generator velocity
  input wire signed [31:0] i_ramp_acc, // Ramp generator acceleration
  input wire [15:0] i_pos_kp, // Position gain
  input wire [15:0] i_pos_tn, // Position reset time
  input wire [31:0] i_pos_emax, // Position max deviation
  input wire [31:0] i_max_speed, // Position stage limit
  input wire [15:0] i_vel_kp, // Velocity gain
  input wire [15:0] i_vel_tn, // Velocity reset time
  input wire [31:0] i_vel_emax, // Velocity max deviation
  input wire [31:0] i_max_current, // Velocity stage limit
  input wire [15:0] i_cur_kp, // Current gain
  input wire [15:0] i_cur_tn, // Current reset time
  input wire [31:0] i_cur_emax, // Current max deviation
  input wire [31:0] i_max_pwm, // Current stage limit
  input wire [15:0] i_leg_kp, // Legacy common gain
  input wire [15:0] i_leg_tn, // Legacy common reset time
  input wire [15:0] i_vff_fac, // Velocity feed-forward, tenths percent
  input wire [15:0] i_aff_fac, // Accel feed-forward, tenths percent
  input wire [31:0] i_aff_scale, // Accel feed-forward scaling factor
  input wire [15:0] i_uff_fac, // Voltage feed-forward, tenths percent
  input wire [31:0] i_u_rated, // Voltage for rated current
  input wire i_step, // Step pulse pin
  input wire i_dir, // Direction pin
  input wire [15:0] i_cd_mul, // Step multiplier
  input wire [15:0] i_cd_div, // Step divider
  output reg signed [31:0] o_pwm, // Current stage voltage output
  output reg signed [31:0] o_vel_cmd, // Velocity set point into velocity stage
  output reg signed [31:0] o_cur_cmd, // Current set point into current stage
  output reg signed [31:0] o_step_pos, // Scaled clock-direction position
  output reg o_pos_run, // Position stage running
  output reg o_vel_run, // Velocity stage running
  output reg o_new_params, // New parameter set in use
  output reg o_convert_req // Pulse: convert legacy set, software must save
);

  // ----------------------------------------------------------------
  // Loop enables
  // ----------------------------------------------------------------
  localparam CLS_OTHER = 2'h0;
  localparam CLS_POS = 2'h1;
  localparam CLS_VEL = 2'h2;
  localparam CLS_TRQ = 2'h3;

  // Unknown mode codes fall into the idle class: only the inner loops run
  function [1:0] mode_class;
    input [3:0] m;
    begin
      case (m)
        `MODE_PROF_POS, `MODE_HOMING, `MODE_INTERP_POS, `MODE_CYC_POS, `MODE_CLK_DIR:
          mode_class = CLS_POS;
        `MODE_VELOCITY, `MODE_PROF_VEL, `MODE_CYC_VEL:
          mode_class = CLS_VEL;
        `MODE_PROF_TRQ, `MODE_CYC_TRQ:
          mode_class = CLS_TRQ;
        default:
          mode_class = CLS_OTHER;
      endcase
    end
  endfunction

  wire [1:0] cls = mode_class(i_mode);
  wire torque_mode = (cls == CLS_TRQ);
  wire vel_mode = (cls == CLS_VEL);
  wire pos_mode = (cls == CLS_POS);
  wire pos_run = pos_mode || (vel_mode && i_cfg[`CFG_POS_IN_VEL_BIT]);
  wire vel_run = !(torque_mode && i_cfg[`CFG_REAL_TORQUE_BIT]);
  wire cur_run = 1'b1;

  // ----------------------------------------------------------------
  // Parameter set choice
  // ----------------------------------------------------------------
  // Legacy set is the reset default; the selector is only looked at once after release,
  // mimicking a power-on conversion.
  reg new_ff;
  reg seen_ff;
  always @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      new_ff <= 1'b0;
      seen_ff <= 1'b0;
      o_convert_req <= 1'b0;
    end
    else
    begin
      seen_ff <= 1'b1;
      o_convert_req <= 1'b0;
      if (!seen_ff)
      begin
        new_ff <= !i_legacy_sel;
        o_convert_req <= !i_legacy_sel;
      end
    end
  end

  wire [15:0] pkp = new_ff ? i_pos_kp : i_leg_kp;
  wire [15:0] ptn = new_ff ? i_pos_tn : i_leg_tn;
  wire [15:0] vkp = new_ff ? i_vel_kp : i_leg_kp;
  wire [15:0] vtn = new_ff ? i_vel_tn : i_leg_tn;
  wire [15:0] ckp = new_ff ? i_cur_kp : i_leg_kp;
  wire [15:0] ctn = new_ff ? i_cur_tn : i_leg_tn;

  // ----------------------------------------------------------------
  // Feed-forward terms
  // ----------------------------------------------------------------
  function signed [31:0] permille;
    input signed [31:0] v;
    input [15:0] f;
    reg signed [63:0] p;
    begin
      p = v * $signed({48'h0, f});
      p = p / 64'sd1000;
      permille = p[31:0];
    end
  endfunction

  wire signed [31:0] vff = pos_run ? permille(i_ramp_vel, i_vff_fac) : 32'sh0;
  wire signed [63:0] acc_s = i_ramp_acc * $signed({32'h0, i_aff_scale});
  wire signed [31:0] acc_cur = acc_s[31:0];
  wire signed [31:0] aff = torque_mode ? 32'sh0 : permille(acc_cur, i_aff_fac);

  // ----------------------------------------------------------------
  // Cascade
  // ----------------------------------------------------------------
  wire signed [31:0] pos_y;
  wire signed [31:0] vel_y;
  wire signed [31:0] cur_y;
  wire signed [31:0] vel_in = pos_run ? pos_y + vff : i_vel_set;
  wire signed [31:0] cur_in = vel_run ? vel_y + aff : i_cur_set;
  wire signed [63:0] cur_u_p = cur_in * $signed({32'h0, i_u_rated});
  wire signed [63:0] cur_u_q = (i_max_current == 32'h0) ? 64'sh0 :
                               cur_u_p / $signed({32'h0, i_max_current});
  // Voltage that would drive the commanded current, before the factor
  wire signed [31:0] cur_in_u = cur_u_q[31:0];
  wire signed [31:0] uff = (i_uff_fac == 16'h0) ? 32'sh0 :
                           permille(cur_in_u, i_uff_fac);

  pi_stage u_pos
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_run(pos_run),
    .i_err(i_pos_set - i_pos_act),
    .i_kp(pkp),
    .i_tn(ptn),
    .i_emax(i_pos_emax),
    .i_ymax(i_max_speed),
    .o_y(pos_y)
  );

  pi_stage u_vel
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_run(vel_run),
    .i_err(vel_in - i_vel_act),
    .i_kp(vkp),
    .i_tn(vtn),
    .i_emax(i_vel_emax),
    .i_ymax(i_max_current),
    .o_y(vel_y)
  );

  pi_stage u_cur
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_run(cur_run),
    .i_err(cur_in - i_cur_act),
    .i_kp(ckp),
    .i_tn(ctn),
    .i_emax(i_cur_emax),
    .i_ymax(i_max_pwm),
    .o_y(cur_y)
  );

  // Voltage feed-forward is added after the clamp so it acts immediately;
  // the sum is clamped again to keep PWM in range.
  wire signed [32:0] u_sum = {cur_y[31], cur_y} + {uff[31], uff};
  wire signed [32:0] u_lim = {1'b0, i_max_pwm};
  wire signed [31:0] u_out = (u_sum > u_lim) ? i_max_pwm :
                             (u_sum < -u_lim) ? -i_max_pwm : u_sum[31:0];

  // ----------------------------------------------------------------
  // Clock-direction input, three-stage sampling
  // ----------------------------------------------------------------
  reg [2:0] step_sy_ff;
  reg [2:0] dir_sy_ff;
  reg step_q_ff;
  reg dir_q_ff;
  reg signed [31:0] acc_ff;
  always @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      step_sy_ff <= 3'h0;
      dir_sy_ff <= 3'h0;
      step_q_ff <= 1'b0;
      dir_q_ff <= 1'b0;
    end
    else
    begin
      step_sy_ff <= {step_sy_ff[1:0], i_step};
      dir_sy_ff <= {dir_sy_ff[1:0], i_dir};
      if (step_sy_ff[1] == step_sy_ff[2])
        step_q_ff <= step_sy_ff[2];
      if (dir_sy_ff[1] == dir_sy_ff[2])
        dir_q_ff <= dir_sy_ff[2];
    end
  end

  wire step_rise = (step_sy_ff[1] == step_sy_ff[2]) && step_sy_ff[2] && !step_q_ff;
  // Remainder carried in acc_ff so fractional steps are never lost.
  wire [15:0] div_nz = (i_cd_div == 16'h0) ? 16'h1 : i_cd_div;
  wire signed [31:0] acc_add = acc_ff + (dir_q_ff ? -$signed({16'h0, i_cd_mul}) :
                                         $signed({16'h0, i_cd_mul}));
  wire signed [31:0] whole = acc_add / $signed({16'h0, div_nz});
  always @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      acc_ff <= 32'sh0;
      o_step_pos <= 32'sh0;
    end
    else if (step_rise && i_mode == `MODE_CLK_DIR)
    begin
      acc_ff <= acc_add - whole * $signed({16'h0, div_nz});
      o_step_pos <= o_step_pos + whole;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_pwm <= 32'sh0;
      o_vel_cmd <= 32'sh0;
      o_cur_cmd <= 32'sh0;
      o_pos_run <= 1'b0;
      o_vel_run <= 1'b0;
      o_new_params <= 1'b0;
    end
    else
    begin
      o_pwm <= u_out;
      o_vel_cmd <= vel_in;
      o_cur_cmd <= cur_in;
      o_pos_run <= pos_run;
      o_vel_run <= vel_run;
      o_new_params <= new_ff;
    end
  end

endmodule // cascaded_pi_motor_control

// *** tb/pi_props.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Port checks of the PI cascade
// ----------------------------------------
module pi_props
(
  input wire i_clk_sys, // Clock
  input wire i_rst_b, // Reset, active low
  input wire [3:0] i_mode, // Mode
  input wire [7:0] i_cfg, // Config bits
  input wire i_legacy_sel, // Legacy selector
  input wire [31:0] i_max_pwm, // Current stage limit
  input wire signed [31:0] o_pwm, // Voltage out
  input wire signed [31:0] o_step_pos, // Step position
  input wire o_pos_run, // Position stage on
  input wire o_vel_run, // Velocity stage on
  input wire o_new_params, // New set in use
  input wire o_convert_req // Convert pulse
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  wire tq = (i_mode == 4'h4) || (i_mode == 4'ha);
  wire pm = (i_mode == 4'h1) || (i_mode == 4'h6) || (i_mode == 4'h7) || (i_mode == 4'h8)
    || (i_mode == 4'hb);
  wire vm = (i_mode == 4'h2) || (i_mode == 4'h3) || (i_mode == 4'h9);
  wire signed [32:0] lim = {1'b0, i_max_pwm};
  // Steps still in the pin synchroniser are dropped once the mode is left
  sequence no_clkdir_s;
    (i_mode != 4'hb) [*5];
  endsequence
  sequence conv_s;
    o_convert_req ##1 !o_convert_req;
  endsequence
  vel_run_a: assert property (!(tq && i_cfg[5]) |=> o_vel_run)
    else $error("velocity stage idle");
  real_torque_a: assert property (tq && i_cfg[5] |=> !o_vel_run)
    else $error("velocity stage runs in unlimited torque");
  pos_modes_a: assert property (pm |=> o_pos_run)
    else $error("position stage idle");
  vel_pos_on_a: assert property (vm && i_cfg[1] |=> o_pos_run)
    else $error("position stage idle with bit 1");
  vel_pos_off_a: assert property (vm && !i_cfg[1] |=> !o_pos_run)
    else $error("position stage runs without bit 1");
  pwm_clamp_a: assert property ($stable(i_max_pwm) |-> o_pwm <= lim && o_pwm >= -lim)
    else $error("voltage output beyond limit");
  convert_once_a: assert property ($rose(i_rst_b) && !i_legacy_sel |-> ##[0:2] conv_s)
    else $error("no single convert pulse");
  pulse_one_a: assert property (o_convert_req |=> !o_convert_req)
    else $error("convert pulse too long");
  legacy_keep_a: assert property ($rose(i_rst_b) && i_legacy_sel |=>
    (!o_new_params && !o_convert_req) [*3])
    else $error("legacy set not kept");
  step_hold_a: assert property (no_clkdir_s |=> $stable(o_step_pos))
    else $error("step position moved outside mode");
endmodule // pi_props
bind cascaded_pi_motor_control pi_props pi_props_i (.*);

// *** tb/motor_feedback_model.sv ***
`timescale 1ns/100ps
module motor_feedback_model
(
  input wire i_clk_sys, // Clock
  input wire i_rst_b, // Reset, active low
  input wire signed [31:0] i_pos_meas, // Shaft position
  input wire signed [31:0] i_vel_meas, // Shaft speed
  input wire signed [31:0] i_cur_meas, // Winding current
  output reg signed [31:0] o_pos_act, // Sampled position
  output reg signed [31:0] o_vel_act, // Sampled speed
  output reg signed [31:0] o_cur_act // Sampled current
);
  // Sensors report one cycle late, so the loop never sees a same-cycle echo
  always @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b)
      {o_pos_act, o_vel_act, o_cur_act} <= 96'h0;
    else
      {o_pos_act, o_vel_act, o_cur_act} <= {i_pos_meas, i_vel_meas, i_cur_meas};
endmodule // motor_feedback_model

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  reg i_clk_sys, i_rst_b, i_legacy_sel, i_step, i_dir, conv_seen;
  reg [3:0] i_mode;
  reg [7:0] i_cfg;
  reg signed [31:0] i_pos_set, i_vel_set, i_cur_set, i_ramp_vel, i_ramp_acc, pos_m, vel_m, cur_m;
  reg [15:0] i_pos_kp, i_pos_tn, i_vel_kp, i_vel_tn, i_cur_kp, i_cur_tn, i_leg_kp, i_leg_tn;
  reg [15:0] i_vff_fac, i_aff_fac, i_uff_fac, i_cd_mul, i_cd_div;
  reg [31:0] i_pos_emax, i_max_speed, i_vel_emax, i_max_current, i_cur_emax, i_max_pwm;
  reg [31:0] i_aff_scale, i_u_rated;
  wire signed [31:0] i_pos_act, i_vel_act, i_cur_act, o_pwm, o_vel_cmd, o_cur_cmd, o_step_pos;
  wire o_pos_run, o_vel_run, o_new_params, o_convert_req;
  integer num_errors, comparisons, cycles;
  motor_feedback_model motor_feedback_model_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_pos_meas(pos_m), .i_vel_meas(vel_m), .i_cur_meas(cur_m),
    .o_pos_act(i_pos_act), .o_vel_act(i_vel_act), .o_cur_act(i_cur_act));
  cascaded_pi_motor_control cascaded_pi_motor_control_i (.*);
  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // Cuts a hang short; also notes the one-cycle convert pulse
  always @(posedge i_clk_sys)
  begin
    cycles <= cycles + 1;
    if (i_rst_b !== 1'b1)
      conv_seen <= 1'b0;
    else if (o_convert_req === 1'b1)
      conv_seen <= 1'b1;
    if (cycles == 2000)
    begin
      num_errors = num_errors + 1;
      report_and_stop;
    end
  end
  task cyc(input integer n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task chk_val(input [31:0] got, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("BAD %0t: got %0h want %0h", $time, got, exp);
    end
  end
  endtask
  task chk_bit(input got, input exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  task report_and_stop;
  begin
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task steps(input integer n);
    repeat (n)
    begin
      i_step = 1'b1;
      cyc(3);
      i_step = 1'b0;
      cyc(3);
    end
  endtask
  task t_modes;
    integer k, c;
  begin
    for (c = 0; c < 2; c = c + 1)
      for (k = 1; k < 12; k = k + 1)
      begin
        i_mode = k[3:0];
        i_cfg = c ? 8'h22 : 8'h00;
        cyc(2);
        chk_bit(o_vel_run, !(c && (k == 4 || k == 10)));
        if (k != 5)
          chk_bit(o_pos_run, (k == 1 || k > 5 && k != 9 && k != 10) || c && (k == 2 || k == 3 || k == 9));
      end
  end
  endtask
  task t_loops;
  begin
    {i_mode, i_cfg, i_pos_set} = {12'h100, 32'h1f4};
    cyc(8);
    chk_val(o_vel_cmd, 32'h1f4);
    i_pos_kp = 16'h01f4;
    cyc(8);
    chk_val(o_vel_cmd, 32'hfa);
    {i_pos_kp, i_pos_set} = {16'h03e8, -32'hbb8};
    cyc(8);
    chk_val(o_vel_cmd, -32'h3e8);
    {i_pos_set, i_pos_tn} = {32'h64, 16'h0001};
    cyc(40);
    chk_val(o_vel_cmd, 32'h3e8);
    i_pos_tn = 16'h0;
    cyc(8);
    chk_val(o_vel_cmd, 32'h64);
    {i_pos_set, i_ramp_vel, i_vff_fac} = {32'h0, 32'h7d0, 16'h01f4};
    cyc(8);
    chk_val(o_vel_cmd, 32'h3e8);
    {i_mode, i_vel_set} = {4'h2, 32'h4d};
    cyc(8);
    chk_val(o_vel_cmd, 32'h4d);
    {i_vel_set, i_ramp_acc, i_aff_fac} = {32'h0, 32'ha, 16'h01f4};
    cyc(8);
    chk_val(o_cur_cmd, 32'h1f4);
    i_uff_fac = 16'h03e8;
    cyc(8);
    chk_val(o_pwm, 32'h3e8);
    i_uff_fac = 16'h07d0;
    cyc(8);
    chk_val(o_pwm, 32'h5dc);
    {i_uff_fac, i_cur_kp} = {16'h0, 16'h03e8};
    cyc(8);
    chk_val(o_pwm, 32'h2ee);
    {i_mode, i_cfg, i_cur_set} = {12'h400, 32'h12c};
    cyc(8);
    chk_val(o_cur_cmd, 32'h0);
    i_cfg = 8'h20;
    cyc(8);
    chk_val(o_cur_cmd, 32'h12c);
    {i_mode, i_cfg} = 12'hb00;
    steps(3);
    cyc(8);
    chk_val(o_step_pos, 32'h6);
    i_mode = 4'h1;
    steps(2);
    chk_val(o_step_pos, 32'h6);
  end
  endtask
  task t_legacy;
  begin
    {i_rst_b, i_legacy_sel, i_leg_kp} = {2'h1, 16'h01f4};
    {i_ramp_vel, i_vff_fac, i_pos_set} = {48'h0, 32'h1f4};
    cyc(2);
    i_rst_b = 1'b1;
    cyc(8);
    chk_bit(o_new_params, 1'b0);
    chk_bit(conv_seen, 1'b0);
    chk_val(o_vel_cmd, 32'hfa);
  end
  endtask
  initial
  begin
    {i_rst_b, i_legacy_sel, i_step, i_dir} = 4'h0;
    {i_mode, i_cfg, i_vel_set, i_cur_set, i_ramp_vel, i_ramp_acc} = {4'h1, 136'h0};
    {i_pos_set, pos_m, vel_m, cur_m} = 128'h0;
    {i_pos_kp, i_vel_kp, i_leg_kp, i_cd_mul, i_cd_div} = {48'h03e8_03e8_03e8, 32'h0004_0002};
    {i_pos_tn, i_vel_tn, i_cur_kp, i_cur_tn, i_leg_tn, i_vff_fac, i_aff_fac, i_uff_fac} = 128'h0;
    {i_pos_emax, i_max_speed, i_vel_emax, i_max_current, i_cur_emax} = {5{32'h3e8}};
    {i_max_pwm, i_aff_scale, i_u_rated} = {32'h5dc, 32'h64, 32'h7d0};
    {num_errors, comparisons, cycles} = 96'h0;
    cyc(16);
    i_rst_b = 1'b1;
    cyc(4);
    chk_bit(conv_seen, 1'b1);
    chk_bit(o_new_params, 1'b1);
    t_modes;
    t_loops;
    t_legacy;
    report_and_stop;
  end
endmodule // tb_top
